// ===== rtl/rcf_consts.svh
// Purpose: offsets, field positions and reset values of the reset-cause flag block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: definitions only
`ifndef RCF_CONSTS_SVH
`define RCF_CONSTS_SVH

`define RCF_ADDR_W 12
`define RCF_DATA_W 8

// register offsets
`define RCF_BCTL_OFS 12'h191
`define RCF_FLAGS_OFS 12'h192
`define RCF_MEM_VIOLATION_FLAG_OFS 12'h193
`define RCF_IRQ_STAT_OFS 12'h194
`define RCF_IRQ_MASK_OFS 12'h195

// reset_cause_flags field positions
`define RCF_BROWNOUT_BIT 0
`define RCF_POWER_ON_BIT 1
`define RCF_INSTR_BIT 2
`define RCF_EXT_PIN_BIT 3
`define RCF_WDT_BIT 4
`define RCF_WWV_BIT 5
`define RCF_STK_UNDER_BIT 6
`define RCF_STK_OVER_BIT 7

// mem_violation_flags and brownout_ctl field positions
`define RCF_MEM_VIOLATION_FLAG_BIT 1
`define RCF_SOFT_EN_BIT 7
`define RCF_READY_BIT 0

// interrupt status / mask bit positions
`define RCF_IRQ_BROWNOUT 0
`define RCF_IRQ_POWER_ON 1
`define RCF_IRQ_INSTR 2
`define RCF_IRQ_EXT_PIN 3
`define RCF_IRQ_WATCHDOG 4
`define RCF_IRQ_STK_OVER 5
`define RCF_IRQ_STK_UNDER 6
`define RCF_IRQ_MEM_VIOLATION_FLAG 7
`define RCF_IRQ_W 8

// values loaded on power-on; brown-out keeps power_on bit and clears brownout bit
`define RCF_FLAGS_POR_VAL 8'h3D
`define RCF_FLAGS_BOR_VAL 8'h3C
`define RCF_MEM_VIOLATION_FLAG_RST_VAL 1'h1
`define RCF_SOFT_EN_RST_VAL 1'h1
`define RCF_IRQ_MASK_RST_VAL 8'h00

`endif

// ===== rtl/rcf_pkg.sv
// Purpose: shared types of the reset-cause flag block
// Assumes: widths from rcf_consts.svh
// Notes: types only
`include "rcf_consts.svh"

package rcf_pkg;

  typedef logic [`RCF_ADDR_W-1:0] addr_t;
  typedef logic [`RCF_DATA_W-1:0] byte_t;

  typedef struct packed {
    byte_t flags;
    logic mem_flag;
    logic soft_en;
    byte_t rdata;
  } cause_state_t;

endpackage : rcf_pkg

// ===== rtl/rcf_irq_flags.sv
// Purpose: sticky event bits with write-one-to-clear, a mask and one level interrupt
// Assumes: events are one-cycle pulses, synchronous to clk
// Notes: an event in the clearing cycle keeps its bit set
`timescale 1ns/1ns
`default_nettype none

module rcf_irq_flags #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // events and software access
  input wire logic [WIDTH-1:0] evt,
  input wire logic [WIDTH-1:0] clr,
  input wire logic mask_wr,
  input wire logic [WIDTH-1:0] mask_data,
  // state and interrupt
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
  } irq_state_t;

  irq_state_t s_reg;
  irq_state_t s_next;
  logic [WIDTH-1:0] status_upd;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign status_upd[i] = evt[i] | (s_reg.status[i] & ~clr[i]);
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    if (ce) begin
      s_next.status = status_upd;
      if (mask_wr) begin
        s_next.mask = mask_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign status = s_reg.status;
  assign mask = s_reg.mask;
  assign irq = |(s_reg.status & s_reg.mask);

  sticky_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && (evt != '0) |=> (s_reg.status & $past(evt)) == $past(evt))
    else $error("event did not set its status bit");

  w1c_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && (evt == '0) && (clr != '0) |=> (s_reg.status & $past(clr)) == '0)
    else $error("write one did not clear status bit");

  irq_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !mask_wr && ((evt & s_reg.mask) != '0) |=> irq)
    else $error("unmasked event did not raise interrupt");

endmodule : rcf_irq_flags

`default_nettype wire

// ===== rtl/reset_cause_flags.sv
// Purpose: reset-cause flag registers with sticky interrupt reporting
// Assumes: cause events are one-cycle pulses from the reset controller
// Notes: power-on reloads every flag, brown-out every flag but the power_on bit; other causes touch one bit
`timescale 1ns/1ns
`default_nettype none

`include "rcf_consts.svh"

module reset_cause_flags (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  // reset cause events
  input wire logic POWER_ON_EVT,
  input wire logic BROWNOUT_EVT,
  input wire logic WDT_TIMEOUT_EVT,
  input wire logic WDT_WINDOW_EVT,
  input wire logic EXT_RESET_PIN_EVT,
  input wire logic RESET_INSTR_EVT,
  input wire logic STACK_OVER_EVT,
  input wire logic STACK_UNDER_EVT,
  input wire logic MEM_VIOL_EVT,
  // brown-out circuit
  input wire logic BROWNOUT_READY,
  output logic SOFT_BROWNOUT_EN,
  // register port
  input wire rcf_pkg::addr_t ADDR,
  input wire rcf_pkg::byte_t WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output rcf_pkg::byte_t RD_DATA,
  // interrupt
  output logic IRQ
);
  import rcf_pkg::*;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  cause_state_t s_reg;
  cause_state_t s_next;
  byte_t irq_status;
  byte_t irq_mask;
  logic [`RCF_IRQ_W-1:0] irq_evt;
  logic wr_flags;
  logic wr_mem_violation_flag;
  logic wr_bctl;
  logic any_evt;

  function automatic logic hit(input addr_t a, input addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  // release reset through two flops
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign wr_flags = WR_STB && hit(ADDR, `RCF_FLAGS_OFS);
  assign wr_mem_violation_flag = WR_STB && hit(ADDR, `RCF_MEM_VIOLATION_FLAG_OFS);
  assign wr_bctl = WR_STB && hit(ADDR, `RCF_BCTL_OFS);
  assign any_evt = POWER_ON_EVT | BROWNOUT_EVT | WDT_TIMEOUT_EVT | WDT_WINDOW_EVT |
                   EXT_RESET_PIN_EVT | RESET_INSTR_EVT | STACK_OVER_EVT |
                   STACK_UNDER_EVT | MEM_VIOL_EVT;

  always_comb begin
    s_next = s_reg;
    if (CLK_EN) begin
      if (wr_flags) begin
        s_next.flags = WR_DATA;
      end
      if (wr_mem_violation_flag) begin
        s_next.mem_flag = WR_DATA[`RCF_MEM_VIOLATION_FLAG_BIT];
      end
      if (wr_bctl) begin
        s_next.soft_en = WR_DATA[`RCF_SOFT_EN_BIT];
      end
      // hardware events win over a same-cycle write
      // watchdog time-out clear
      if (WDT_TIMEOUT_EVT) begin
        s_next.flags[`RCF_WDT_BIT] = 1'h0;
      end
      if (WDT_WINDOW_EVT) begin
        s_next.flags[`RCF_WWV_BIT] = 1'h0;
      end
      if (EXT_RESET_PIN_EVT) begin
        s_next.flags[`RCF_EXT_PIN_BIT] = 1'h0;
      end
      if (RESET_INSTR_EVT) begin
        s_next.flags[`RCF_INSTR_BIT] = 1'h0;
      end
      if (STACK_OVER_EVT) begin
        s_next.flags[`RCF_STK_OVER_BIT] = 1'h1;
      end
      if (STACK_UNDER_EVT) begin
        s_next.flags[`RCF_STK_UNDER_BIT] = 1'h1;
      end
      if (MEM_VIOL_EVT) begin
        s_next.mem_flag = 1'h0;
      end
      if (POWER_ON_EVT) begin
        s_next.flags = `RCF_FLAGS_POR_VAL;
        s_next.mem_flag = `RCF_MEM_VIOLATION_FLAG_RST_VAL;
        s_next.soft_en = `RCF_SOFT_EN_RST_VAL;
      end else if (BROWNOUT_EVT) begin
        s_next.flags = `RCF_FLAGS_BOR_VAL;
        s_next.flags[`RCF_POWER_ON_BIT] = s_reg.flags[`RCF_POWER_ON_BIT];
        s_next.mem_flag = `RCF_MEM_VIOLATION_FLAG_RST_VAL;
        s_next.soft_en = `RCF_SOFT_EN_RST_VAL;
      end
      // read data stand for one enabled cycle only; they hold while CLK_EN is low
      s_next.rdata = 8'h00;
      if (RD_STB) begin
        if (hit(ADDR, `RCF_FLAGS_OFS)) begin
          s_next.rdata = s_reg.flags;
        end else if (hit(ADDR, `RCF_MEM_VIOLATION_FLAG_OFS)) begin
          s_next.rdata[`RCF_MEM_VIOLATION_FLAG_BIT] = s_reg.mem_flag;
        end else if (hit(ADDR, `RCF_BCTL_OFS)) begin
          s_next.rdata[`RCF_SOFT_EN_BIT] = s_reg.soft_en;
          s_next.rdata[`RCF_READY_BIT] = BROWNOUT_READY;
        end else if (hit(ADDR, `RCF_IRQ_STAT_OFS)) begin
          s_next.rdata = irq_status;
        end else if (hit(ADDR, `RCF_IRQ_MASK_OFS)) begin
          s_next.rdata = irq_mask;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.flags <= `RCF_FLAGS_POR_VAL;
      s_reg.mem_flag <= `RCF_MEM_VIOLATION_FLAG_RST_VAL;
      s_reg.soft_en <= `RCF_SOFT_EN_RST_VAL;
      s_reg.rdata <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  assign irq_evt[`RCF_IRQ_BROWNOUT] = BROWNOUT_EVT;
  assign irq_evt[`RCF_IRQ_POWER_ON] = POWER_ON_EVT;
  assign irq_evt[`RCF_IRQ_INSTR] = RESET_INSTR_EVT;
  assign irq_evt[`RCF_IRQ_EXT_PIN] = EXT_RESET_PIN_EVT;
  assign irq_evt[`RCF_IRQ_WATCHDOG] = WDT_TIMEOUT_EVT | WDT_WINDOW_EVT;
  assign irq_evt[`RCF_IRQ_STK_OVER] = STACK_OVER_EVT;
  assign irq_evt[`RCF_IRQ_STK_UNDER] = STACK_UNDER_EVT;
  assign irq_evt[`RCF_IRQ_MEM_VIOLATION_FLAG] = MEM_VIOL_EVT;

  rcf_irq_flags #(
    .WIDTH(`RCF_IRQ_W)
  ) u_irq (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .ce(CLK_EN),
    .evt(irq_evt),
    .clr((WR_STB && hit(ADDR, `RCF_IRQ_STAT_OFS)) ? WR_DATA : 8'h00),
    .mask_wr(WR_STB && hit(ADDR, `RCF_IRQ_MASK_OFS)),
    .mask_data(WR_DATA),
    .status(irq_status),
    .mask(irq_mask),
    .irq(IRQ)
  );

  assign RD_DATA = s_reg.rdata;
  assign SOFT_BROWNOUT_EN = s_reg.soft_en;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!rst_n);

  wdt_flag_clear_a: assert property (
    CLK_EN && WDT_TIMEOUT_EVT && !POWER_ON_EVT && !BROWNOUT_EVT
    |=> !s_reg.flags[`RCF_WDT_BIT])
    else $error("watchdog flag not cleared");

  ext_pin_clear_a: assert property (
    CLK_EN && EXT_RESET_PIN_EVT && !POWER_ON_EVT && !BROWNOUT_EVT
    |=> !s_reg.flags[`RCF_EXT_PIN_BIT])
    else $error("pin reset flag not cleared");

  instr_flag_clear_a: assert property (
    CLK_EN && RESET_INSTR_EVT && !POWER_ON_EVT && !BROWNOUT_EVT
    |=> !s_reg.flags[`RCF_INSTR_BIT])
    else $error("instruction flag not cleared");

  power_on_load_a: assert property (
    CLK_EN && POWER_ON_EVT
    |=> s_reg.flags == `RCF_FLAGS_POR_VAL && s_reg.mem_flag && SOFT_BROWNOUT_EN)
    else $error("power-on values not loaded");

  brownout_keep_a: assert property (
    CLK_EN && BROWNOUT_EVT && !POWER_ON_EVT
    |=> !s_reg.flags[`RCF_BROWNOUT_BIT] && s_reg.mem_flag
        && s_reg.flags[`RCF_POWER_ON_BIT] == $past(s_reg.flags[`RCF_POWER_ON_BIT]))
    else $error("brown-out reload wrong");

  mem_violation_flag_flag_clear_a: assert property (
    CLK_EN && MEM_VIOL_EVT && !POWER_ON_EVT && !BROWNOUT_EVT |=> !s_reg.mem_flag)
    else $error("violation flag not cleared");

  mem_violation_flag_read_zero_a: assert property (
    CLK_EN && RD_STB && ADDR == `RCF_MEM_VIOLATION_FLAG_OFS
    |=> (RD_DATA & ~8'h02) == 8'h00 && RD_DATA[`RCF_MEM_VIOLATION_FLAG_BIT] == $past(s_reg.mem_flag))
    else $error("second register read wrong");

  flags_hold_a: assert property (
    (!CLK_EN || (!any_evt && !wr_flags)) |=> $stable(s_reg.flags))
    else $error("flags changed without cause");

  write_store_a: assert property (
    CLK_EN && wr_flags && !any_evt |=> s_reg.flags == $past(WR_DATA))
    else $error("flag write not stored");

  wwv_flag_clear_a: assert property (
    CLK_EN && WDT_WINDOW_EVT && !POWER_ON_EVT && !BROWNOUT_EVT
    |=> !s_reg.flags[`RCF_WWV_BIT] && (!irq_mask[`RCF_IRQ_WATCHDOG] || IRQ))
    else $error("window flag not cleared");

  stack_flag_set_a: assert property (
    CLK_EN && STACK_OVER_EVT && !POWER_ON_EVT && !BROWNOUT_EVT
    |=> s_reg.flags[`RCF_STK_OVER_BIT])
    else $error("stack overflow flag not set");

  stack_under_set_a: assert property (
    CLK_EN && STACK_UNDER_EVT && !POWER_ON_EVT && !BROWNOUT_EVT
    |=> s_reg.flags[`RCF_STK_UNDER_BIT])
    else $error("stack underflow flag not set");

  ext_pin_rearm_a: assert property (
    CLK_EN && wr_flags && WR_DATA[`RCF_EXT_PIN_BIT] && !EXT_RESET_PIN_EVT
    && !POWER_ON_EVT && !BROWNOUT_EVT |=> s_reg.flags[`RCF_EXT_PIN_BIT])
    else $error("pin reset flag not kept at one");

  instr_rearm_a: assert property (
    CLK_EN && wr_flags && WR_DATA[`RCF_INSTR_BIT] && !RESET_INSTR_EVT
    && !POWER_ON_EVT && !BROWNOUT_EVT |=> s_reg.flags[`RCF_INSTR_BIT])
    else $error("instruction flag not kept at one");

  power_on_hold_a: assert property (
    CLK_EN && !POWER_ON_EVT && !wr_flags
    |=> s_reg.flags[`RCF_POWER_ON_BIT] == $past(s_reg.flags[`RCF_POWER_ON_BIT]))
    else $error("power-on flag changed by another reset");

  mem_violation_flag_write_a: assert property (
    CLK_EN && wr_mem_violation_flag && !MEM_VIOL_EVT && !POWER_ON_EVT && !BROWNOUT_EVT
    |=> s_reg.mem_flag == $past(WR_DATA[`RCF_MEM_VIOLATION_FLAG_BIT]))
    else $error("violation flag write not stored");

  mem_violation_flag_hold_a: assert property (
    !CLK_EN || (!wr_mem_violation_flag && !MEM_VIOL_EVT && !POWER_ON_EVT && !BROWNOUT_EVT)
    |=> $stable(s_reg.mem_flag))
    else $error("violation flag changed without cause");

  bctl_read_a: assert property (
    CLK_EN && RD_STB && ADDR == `RCF_BCTL_OFS
    |=> RD_DATA[6:1] == 6'h00 && RD_DATA[`RCF_SOFT_EN_BIT] == $past(s_reg.soft_en)
        && RD_DATA[`RCF_READY_BIT] == $past(BROWNOUT_READY))
    else $error("brown-out control read wrong");

  soft_en_keep_a: assert property (
    !CLK_EN || (!wr_bctl && !POWER_ON_EVT && !BROWNOUT_EVT) |=> $stable(SOFT_BROWNOUT_EN))
    else $error("soft brown-out enable changed without cause");

  read_one_cycle_a: assert property (
    CLK_EN && RD_STB ##1 CLK_EN && !RD_STB |=> RD_DATA == 8'h00)
    else $error("read data stood too long");

  cov_pin_reset_c: cover property (CLK_EN && EXT_RESET_PIN_EVT);
  cov_rearm_c: cover property (CLK_EN && wr_flags && WR_DATA[`RCF_EXT_PIN_BIT]);
  cov_brownout_c: cover property (CLK_EN && BROWNOUT_EVT);
  cov_irq_c: cover property (IRQ ##1 !IRQ);

endmodule : reset_cause_flags

`default_nettype wire

// ===== tb/test_reset_cause_flags.sv
// Purpose: self-checking bench for the reset-cause flag block
// Assumes: one 25 MHz clock; read data answers one cycle after the strobe
// Notes: reads queue their expected byte; a monitor compares when data arrives
`timescale 1ns/1ns
`default_nettype none
`include "rcf_consts.svh"

module test_reset_cause_flags;
  import rcf_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [8:0] evt = '0;
  logic bor_rdy = 1'b0;
  addr_t addr = '0;
  byte_t wdata = '0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  byte_t rdata;
  logic soft_en;
  logic irq;
  byte_t exp_q[$];
  logic rd_pend = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h52AF;
  byte_t ef, es, v;
  logic em, exp_soft;
  // status bit raised by each event, in the order of evt
  int sbit[9] = '{1, 0, 4, 4, 3, 2, 5, 6, 7};

  always #20 sys_clk = ~sys_clk;

  reset_cause_flags i_reset_cause_flags (
    .SYS_CLK(sys_clk), .ARST_N(arst_n), .CLK_EN(clk_en),
    .POWER_ON_EVT(evt[0]), .BROWNOUT_EVT(evt[1]), .WDT_TIMEOUT_EVT(evt[2]),
    .WDT_WINDOW_EVT(evt[3]), .EXT_RESET_PIN_EVT(evt[4]), .RESET_INSTR_EVT(evt[5]),
    .STACK_OVER_EVT(evt[6]), .STACK_UNDER_EVT(evt[7]), .MEM_VIOL_EVT(evt[8]),
    .BROWNOUT_READY(bor_rdy), .SOFT_BROWNOUT_EN(soft_en),
    .ADDR(addr), .WR_DATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RD_DATA(rdata), .IRQ(irq)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr_next

  task automatic rnd(output byte_t r);
    seed = lfsr_next(seed);
    r = seed[7:0];
  endtask : rnd

  task automatic check(input string name, input byte_t seen, input byte_t exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input addr_t a, input byte_t d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input addr_t a, input byte_t exp);
    @(posedge sys_clk);
    exp_q.push_back(exp);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
  endtask : rd

  task automatic pulse(input int i);
    @(posedge sys_clk);
    evt <= 9'h001 << i;
    @(posedge sys_clk);
    evt <= '0;
  endtask : pulse

  // read data arrives one cycle after an accepted strobe, zero otherwise
  always @(posedge sys_clk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        check("RD_DATA unexpected", rdata, 8'h00);
      end else begin
        check("RD_DATA", rdata, exp_q.pop_front());
      end
    end else if (arst_n) begin
      check("RD_DATA idle", rdata, 8'h00);
    end
    rd_pend <= rd_stb & clk_en;
  end

  initial begin
    #1000000;
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ef = `RCF_FLAGS_POR_VAL;
    em = 1'b1;
    exp_soft = 1'b1;
    es = 8'h00;
    check("SOFT_BROWNOUT_EN", {7'h00, soft_en}, 8'h01);
    rd(`RCF_FLAGS_OFS, ef);
    rd(`RCF_MEM_VIOLATION_FLAG_OFS, 8'h02);
    rd(`RCF_IRQ_STAT_OFS, 8'h00);
    rd(`RCF_IRQ_MASK_OFS, 8'h00);
    rnd(v);
    wr(12'h190, v);
    rd(12'h190, 8'h00);
    rd(12'h196, 8'h00);
    wr(`RCF_IRQ_MASK_OFS, 8'hFF);
    for (int i = 0; i < 9; i++) begin
      rnd(v);
      wr(`RCF_FLAGS_OFS, v);
      ef = v;
      rnd(v);
      wr(`RCF_MEM_VIOLATION_FLAG_OFS, v);
      em = v[1];
      rnd(v);
      wr(`RCF_BCTL_OFS, v);
      exp_soft = v[7];
      check("IRQ after writes", {7'h00, irq}, 8'h00);
      pulse(i);
      rnd(v);
      bor_rdy <= v[0];
      case (i)
        0: begin
          ef = `RCF_FLAGS_POR_VAL;
          em = 1'b1;
          exp_soft = 1'b1;
        end
        1: begin
          ef = {2'b00, 4'hF, ef[1], 1'b0};
          em = 1'b1;
          exp_soft = 1'b1;
        end
        2: ef[4] = 1'b0;
        3: ef[5] = 1'b0;
        4: ef[3] = 1'b0;
        5: ef[2] = 1'b0;
        6: ef[7] = 1'b1;
        7: ef[6] = 1'b1;
        default: em = 1'b0;
      endcase
      es[sbit[i]] = 1'b1;
      #1;
      check("IRQ", {7'h00, irq}, 8'h01);
      check("SOFT_BROWNOUT_EN", {7'h00, soft_en}, {7'h00, exp_soft});
      rd(`RCF_FLAGS_OFS, ef);
      rd(`RCF_MEM_VIOLATION_FLAG_OFS, {6'h00, em, 1'b0});
      rd(`RCF_BCTL_OFS, {exp_soft, 6'h00, v[0]});
      rd(`RCF_IRQ_STAT_OFS, es);
      wr(`RCF_IRQ_STAT_OFS, es);
      es = 8'h00;
      #1;
      check("IRQ cleared", {7'h00, irq}, 8'h00);
    end
    // masked event stays pending without raising the interrupt
    wr(`RCF_IRQ_MASK_OFS, 8'hF7);
    pulse(4);
    ef[3] = 1'b0;
    #1;
    check("IRQ masked", {7'h00, irq}, 8'h00);
    rd(`RCF_IRQ_STAT_OFS, 8'h08);
    rd(`RCF_FLAGS_OFS, ef);
    wr(`RCF_IRQ_MASK_OFS, 8'hFF);
    #1;
    check("IRQ unmasked", {7'h00, irq}, 8'h01);
    wr(`RCF_IRQ_STAT_OFS, 8'h08);
    rd(`RCF_IRQ_MASK_OFS, 8'hFF);
    // a write strobe while the clock enable is low is ignored
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(`RCF_FLAGS_OFS, ~ef);
    clk_en <= 1'b1;
    rd(`RCF_FLAGS_OFS, ef);
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
endmodule : test_reset_cause_flags
`default_nettype wire
